// >>> eiw_pkg.sv
// Package for the external interrupt and wake-up block
package eiw_pkg;
   // Core timing
   localparam int unsigned CLK_PERIOD_PS = 10_000;
   // Least assertion time in power-down, in ps (50 ns)
   localparam int unsigned PD_MIN_ASSERT_PS = 50_000;
   // Least time rounds up to whole cycles, never below one
   localparam int unsigned PD_MIN_CYC_RAW =
      (PD_MIN_ASSERT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned PD_MIN_CYC = (PD_MIN_CYC_RAW < 1) ? 1 : PD_MIN_CYC_RAW;
   // Core cycles per state time
   localparam int unsigned STATE_CYC = 2;
   localparam int unsigned PH2_IDX = 1;

   typedef enum logic [2:0] {
      EIW_RUN  = 3'h1,
      EIW_IDLE = 3'h2,
      EIW_PD   = 3'h4
   } eiw_mode_e;

   // Wake-up report toward the core
   typedef struct packed {
      logic wake;    // One-cycle resume pulse
      logic service; // Resume into the handler
   } eiw_wake_s;
endpackage

// >>> eiw_ext_irq.sv
// External interrupt edge detection and power-saving wake-up logic
`timescale 1ns/1ps

// Function
// - In run mode a rising edge on the pin sets the pending flag.
// - The pin is sampled once per state time, in phase 2.
// - In power-down a pin assertion of 50 ns or more wakes the device, enabled or not.
// - After a power-down wake the handler runs if enabled, else the next instruction.
// - In idle an asserted other interrupt, or this pin's pending flag (set in run mode) while enabled, wakes the device.
module eiw_ext_irq #(
   parameter int unsigned STATE_CYC  = eiw_pkg::STATE_CYC,
   parameter int unsigned PD_MIN_CYC = eiw_pkg::PD_MIN_CYC
) (
   input  wire logic      core_clk_i,     // Core clock, 100 MHz
   input  wire logic      rst_n_i,        // Synchronous reset, active low
   input  wire logic      clk_en_i,       // Freezes all state when low
   input  wire logic      ext_irq_pin_i,  // External interrupt pin, asynchronous
   input  wire logic      irq_en_i,       // Interrupt enable for this source
   input  wire logic      pend_clr_i,     // Pending clear from the core, pulse
   input  wire logic      idle_req_i,     // Enter idle, pulse
   input  wire logic      pd_req_i,       // Enter power-down, pulse
   input  wire logic      other_irq_i,    // Any other enabled interrupt asserted
   output logic           pend_o,         // Pending flag
   output eiw_pkg::eiw_wake_s wake_o,     // Wake pulse and service select
   output eiw_pkg::eiw_mode_e mode_o      // Current power mode
);
   localparam int unsigned PW = (STATE_CYC > 1) ? $clog2(STATE_CYC) : 1;
   localparam int unsigned CW = $clog2(PD_MIN_CYC + 1);
   localparam logic [PW-1:0] PH_LAST = PW'(STATE_CYC - 1);
   localparam logic [PW-1:0] PH2     = PW'(eiw_pkg::PH2_IDX);
   localparam logic [CW-1:0] PD_CNT  = CW'(PD_MIN_CYC);

   logic          sync1_q;
   logic          sync2_q;
   logic [PW-1:0] phase_q;
   logic          samp_q;
   logic          samp_prev_q;
   logic          samp_vld_q;
   logic          pend_q;
   logic [CW-1:0] pd_cnt_q;
   eiw_pkg::eiw_mode_e mode_q;
   eiw_pkg::eiw_wake_s wake_q;
   logic          ph2;
   logic          rise;
   logic          pd_wake;
   logic          idle_wake;

   // Two-stage synchroniser for the asynchronous pin
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
      end else if (clk_en_i) begin
         sync1_q <= ext_irq_pin_i;
         sync2_q <= sync1_q;
      end
   end

   // State-time phase counter
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         phase_q <= '0;
      end else if (clk_en_i) begin
         phase_q <= (phase_q == PH_LAST) ? '0 : phase_q + PW'(1);
      end
   end

   assign ph2 = (phase_q == PH2);

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         samp_q      <= 1'b0;
         samp_prev_q <= 1'b0;
         samp_vld_q  <= 1'b0;
      end else if (clk_en_i && ph2) begin
         samp_q      <= sync2_q;
         samp_prev_q <= samp_q;
         samp_vld_q  <= 1'b1;
      end
   end

   // A rise is seen in the cycle the phase-2 sample lands, one cycle after phase 2
   logic ph2_d_q;
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         ph2_d_q <= 1'b0;
      end else if (clk_en_i) begin
         ph2_d_q <= ph2;
      end
   end

   assign rise = ph2_d_q && samp_vld_q && samp_q && !samp_prev_q;

   // Set wins over clear
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         pend_q <= 1'b0;
      end else if (clk_en_i) begin
         if (rise && mode_q == eiw_pkg::EIW_RUN) begin
            pend_q <= 1'b1;
         end else if (pend_clr_i) begin
            pend_q <= 1'b0;
         end
      end
   end

   // Power-down: count consecutive high cycles of the synchronised pin
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         pd_cnt_q <= '0;
      end else if (clk_en_i) begin
         if (mode_q != eiw_pkg::EIW_PD || !sync2_q) begin
            pd_cnt_q <= '0;
         end else if (pd_cnt_q != PD_CNT) begin
            pd_cnt_q <= pd_cnt_q + CW'(1);
         end
      end
   end

   assign pd_wake   = (mode_q == eiw_pkg::EIW_PD) && (pd_cnt_q == PD_CNT);
   assign idle_wake = (mode_q == eiw_pkg::EIW_IDLE)
                      && (other_irq_i || (pend_q && irq_en_i));

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         mode_q <= eiw_pkg::EIW_RUN;
         wake_q <= '0;
      end else if (clk_en_i) begin
         wake_q <= '0;
         unique case (mode_q)
            eiw_pkg::EIW_RUN: begin
               if (pd_req_i) begin
                  mode_q <= eiw_pkg::EIW_PD;
               end else if (idle_req_i) begin
                  mode_q <= eiw_pkg::EIW_IDLE;
               end
            end
            eiw_pkg::EIW_IDLE: begin
               if (idle_wake) begin
                  mode_q         <= eiw_pkg::EIW_RUN;
                  wake_q.wake    <= 1'b1;
                  wake_q.service <= 1'b1;
               end
            end
            eiw_pkg::EIW_PD: begin
               if (pd_wake) begin
                  mode_q         <= eiw_pkg::EIW_RUN;
                  wake_q.wake    <= 1'b1;
                  wake_q.service <= irq_en_i;
               end
            end
            default: begin
               mode_q <= eiw_pkg::EIW_RUN;
            end
         endcase
      end
   end

   always_comb begin
      pend_o = pend_q;
      wake_o = wake_q;
      mode_o = mode_q;
   end

   // binds the source; the phase-2 sampling relies on it
   chk_pd_wake_time: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      clk_en_i && mode_q == eiw_pkg::EIW_PD && wake_q.wake == 1'b0
      && pd_cnt_q == PD_CNT |=> wake_q.wake && mode_q == eiw_pkg::EIW_RUN)
      else $error("power-down wake not taken");
   chk_pd_service: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      clk_en_i && pd_wake |=> wake_q.service == $past(irq_en_i))
      else $error("service select wrong after power-down wake");
   chk_rise_sets: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      clk_en_i && rise && mode_q == eiw_pkg::EIW_RUN |=> pend_q)
      else $error("pending not set on rising edge");
   chk_edge_only: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      clk_en_i && !$past(pend_q) && pend_q |-> $past(samp_q) && !$past(samp_prev_q))
      else $error("pending set without low-high sample pair");
   chk_sample_phase: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      clk_en_i && !ph2 |=> $stable(samp_q))
      else $error("sample moved outside phase 2");
   chk_idle_wake: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      clk_en_i && mode_q == eiw_pkg::EIW_IDLE && other_irq_i
      |=> mode_q == eiw_pkg::EIW_RUN && wake_q.wake)
      else $error("idle wake missed");

   // Pending flag holds until cleared and only sets in run mode
   chk_pend_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      clk_en_i && pend_q && !pend_clr_i |=> pend_q)
      else $error("pending flag dropped without clear");
   chk_pend_run_only: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      clk_en_i && !pend_q && mode_q != eiw_pkg::EIW_RUN |=> !pend_q)
      else $error("pending flag set outside run mode");

   // Power-down entry, counter and wake pulse
   chk_pd_enter: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      clk_en_i && mode_q == eiw_pkg::EIW_RUN && pd_req_i |=> mode_q == eiw_pkg::EIW_PD)
      else $error("power-down not entered");
   chk_pd_cnt_drop: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      clk_en_i && mode_q == eiw_pkg::EIW_PD && !sync2_q |=> pd_cnt_q == '0)
      else $error("power-down count kept after pin drop");
   chk_pd_early: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      clk_en_i && mode_q == eiw_pkg::EIW_PD && pd_cnt_q != PD_CNT |=> mode_q == eiw_pkg::EIW_PD)
      else $error("power-down left before the least assertion time");
   chk_wake_pulse: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      clk_en_i && wake_q.wake |=> !wake_q.wake)
      else $error("wake pulse longer than one cycle");

   // Idle wake paths
   chk_idle_pend_wake: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      clk_en_i && mode_q == eiw_pkg::EIW_IDLE && pend_q && irq_en_i
      |=> wake_q.wake && wake_q.service)
      else $error("idle wake on own pending interrupt missed");
   chk_idle_stay: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      clk_en_i && mode_q == eiw_pkg::EIW_IDLE && !idle_wake |=> mode_q == eiw_pkg::EIW_IDLE)
      else $error("idle left without an enabled interrupt");

   // Clock enable low freezes mode, flags and counters
   chk_freeze_mode: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      !clk_en_i |=> $stable(mode_q) && $stable(pend_q) && $stable(wake_q))
      else $error("mode or flags changed while frozen");
   chk_freeze_cnt: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      !clk_en_i |=> $stable(pd_cnt_q) && $stable(phase_q) && $stable(samp_q))
      else $error("counters changed while frozen");
endmodule

// >>> eiw_src_model.sv
// Model of the external event source that drives the interrupt pin
`timescale 1ns/1ps
module eiw_src_model (
   input  wire logic       clk_i,  // Core clock
   input  wire logic [7:0] hold_i, // High time in cycles, taken when nonzero
   output logic            pin_o   // Interrupt pin
);
   logic [7:0] cnt_q;
   initial cnt_q = 8'h00;
   always @(posedge clk_i) begin
      if (cnt_q != 8'h00) begin
         cnt_q <= cnt_q - 8'h01;
      end else begin
         cnt_q <= hold_i;
      end
   end
   // Pin stays high for exactly the requested cycles, low otherwise
   assign pin_o = (cnt_q != 8'h00);
endmodule

// >>> tb_top.sv
// Self-checking testbench for the external interrupt and wake-up block
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
   $display("unexpected %s exp %0h got %0h", n, e, g); end end
module tb_top;
   logic core_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic irq_en_i = 1'b0, pend_clr_i = 1'b0, idle_req_i = 1'b0;
   logic pd_req_i = 1'b0, other_irq_i = 1'b0, pin;
   logic clk_en_i = 1'b1;
   logic [7:0] hold = 8'h00;
   logic pend_o;
   eiw_pkg::eiw_wake_s wake_o;
   eiw_pkg::eiw_mode_e mode_o;
   int errors = 0, cmp_count = 0;
   always #5 core_clk_i = ~core_clk_i;
   eiw_src_model i_src (.clk_i(core_clk_i), .hold_i(hold), .pin_o(pin));
   eiw_ext_irq #(.STATE_CYC(eiw_pkg::STATE_CYC), .PD_MIN_CYC(eiw_pkg::PD_MIN_CYC)) i_dut (
      .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
      .ext_irq_pin_i(pin), .irq_en_i(irq_en_i), .pend_clr_i(pend_clr_i),
      .idle_req_i(idle_req_i), .pd_req_i(pd_req_i), .other_irq_i(other_irq_i),
      .pend_o(pend_o), .wake_o(wake_o), .mode_o(mode_o));
   task automatic close_out();
      if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic t_reset();
      @(posedge core_clk_i);
      rst_n_i <= 1'b0;
      repeat (4) @(posedge core_clk_i);
      #1;
      `CHK("rst_mode", eiw_pkg::EIW_RUN, mode_o)
      `CHK("rst_pend", 1'b0, pend_o)
      `CHK("rst_wake", 1'b0, wake_o.wake)
      @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      repeat (4) @(posedge core_clk_i);
   endtask
   task automatic pin_high(input logic [7:0] n);
      @(posedge core_clk_i);
      hold <= n;
      @(posedge core_clk_i);
      hold <= 8'h00;
   endtask
   task automatic wait_wake(input logic srv);
      for (int i = 0; i < 30 && wake_o.wake !== 1'b1; i++) begin
         @(posedge core_clk_i);
         #1;
      end
      `CHK("wake", 1'b1, wake_o.wake)
      `CHK("service", srv, wake_o.service)
      `CHK("mode", eiw_pkg::EIW_RUN, mode_o)
      @(posedge core_clk_i);
      #1;
      `CHK("wake_end", 1'b0, wake_o.wake)
   endtask
   task automatic t_run_edge();
      pin_high(8'h04);
      for (int i = 0; i < 14 && pend_o !== 1'b1; i++) begin
         @(posedge core_clk_i);
         #1;
      end
      `CHK("pend_set", 1'b1, pend_o)
      @(posedge core_clk_i);
      pend_clr_i <= 1'b1;
      @(posedge core_clk_i);
      pend_clr_i <= 1'b0;
      #1;
      `CHK("pend_clr", 1'b0, pend_o)
   endtask
   task automatic t_pd(input logic en);
      @(posedge core_clk_i);
      irq_en_i <= en;
      pd_req_i <= 1'b1;
      @(posedge core_clk_i);
      pd_req_i <= 1'b0;
      pin_high(8'h02);
      repeat (12) @(posedge core_clk_i);
      #1;
      `CHK("pd_short", eiw_pkg::EIW_PD, mode_o)
      pin_high(8'h0a);
      wait_wake(en);
      repeat (12) @(posedge core_clk_i);
      #1;
      `CHK("pd_no_pend", 1'b0, pend_o)
   endtask
   task automatic t_idle();
      @(posedge core_clk_i);
      idle_req_i <= 1'b1;
      @(posedge core_clk_i);
      idle_req_i <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      #1;
      `CHK("idle", eiw_pkg::EIW_IDLE, mode_o)
      @(posedge core_clk_i);
      other_irq_i <= 1'b1;
      wait_wake(1'b1);
      @(posedge core_clk_i);
      other_irq_i <= 1'b0;
   endtask
   task automatic t_idle_pend();
      @(posedge core_clk_i);
      irq_en_i <= 1'b1;
      pin_high(8'h04);
      for (int i = 0; i < 14 && pend_o !== 1'b1; i++) begin
         @(posedge core_clk_i);
         #1;
      end
      `CHK("idle_pend_set", 1'b1, pend_o)
      @(posedge core_clk_i);
      idle_req_i <= 1'b1;
      @(posedge core_clk_i);
      idle_req_i <= 1'b0;
      wait_wake(1'b1);
      @(posedge core_clk_i);
      pend_clr_i <= 1'b1;
      @(posedge core_clk_i);
      pend_clr_i <= 1'b0;
      #1;
      `CHK("idle_pend_clr", 1'b0, pend_o)
   endtask
   task automatic t_freeze();
      @(posedge core_clk_i);
      idle_req_i <= 1'b1;
      @(posedge core_clk_i);
      idle_req_i  <= 1'b0;
      clk_en_i    <= 1'b0;
      other_irq_i <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      #1;
      `CHK("frz_mode", eiw_pkg::EIW_IDLE, mode_o)
      `CHK("frz_wake", 1'b0, wake_o.wake)
      @(posedge core_clk_i);
      clk_en_i <= 1'b1;
      wait_wake(1'b1);
      @(posedge core_clk_i);
      other_irq_i <= 1'b0;
   endtask
   task automatic t_rst_pd();
      @(posedge core_clk_i);
      pd_req_i <= 1'b1;
      @(posedge core_clk_i);
      pd_req_i <= 1'b0;
      #1;
      `CHK("pd_entry", eiw_pkg::EIW_PD, mode_o)
      t_reset();
   endtask
   initial begin
      t_reset();
      t_run_edge();
      t_pd(1'b0);
      t_pd(1'b1);
      t_idle();
      t_idle_pend();
      t_freeze();
      t_rst_pd();
      t_run_edge();
      close_out();
   end
   initial begin
      repeat (3000) @(posedge core_clk_i);
      errors++;
      close_out();
   end
endmodule
